// File: ccm_top.v
`include "ccm_defs.vh"
`default_nettype none
module ccm_top (
  input  wire                    aclk,
  input  wire                    aresetn,
  input  wire [`CCM_BUS_AW-1:0]  s_axi_awaddr,
  input  wire                    s_axi_awvalid,
  output reg                     s_axi_awready,
  input  wire [31:0]             s_axi_wdata,
  input  wire [3:0]              s_axi_wstrb,
  input  wire                    s_axi_wvalid,
  output reg                     s_axi_wready,
  output reg  [1:0]              s_axi_bresp,
  output reg                     s_axi_bvalid,
  input  wire                    s_axi_bready,
  input  wire [`CCM_BUS_AW-1:0]  s_axi_araddr,
  input  wire                    s_axi_arvalid,
  output reg                     s_axi_arready,
  output reg  [31:0]             s_axi_rdata,
  output reg  [1:0]              s_axi_rresp,
  output reg                     s_axi_rvalid,
  input  wire                    s_axi_rready,
  input  wire                    samp_clk_pin,
  input  wire                    trig_pin,
  input  wire [`CCM_SW-1:0]      samp_data_pin,
  output reg                     dma_valid,
  output reg  [31:0]             dma_addr,
  output reg  [31:0]             dma_data,
  input  wire                    dma_ready,
  output reg                     busy,
  output reg                     irq
);
  localparam ST_IDLE = 2'b00;
  localparam ST_PRE  = 2'b01;
  localparam ST_POST = 2'b10;
  // all ones: the memory depth is a power of two, so this is the top word
  localparam [`CCM_AW-1:0] LAST_ADDR = {`CCM_AW{1'b1}};

  // byte-lane merge for register writes
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  strb;
    integer i;
    begin
      for (i = 0; i < 4; i = i + 1)
        merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  // memory window hit, used by both read and write decode
  function in_mem;
    input [`CCM_BUS_AW-1:0] a;
    begin
      in_mem = a[`CCM_MEM_BIT];
    end
  endfunction

  reg [`CCM_SW-1:0]      mem [0:`CCM_DEPTH-1];
  reg [1:0]              state_q;
  reg [`CCM_AW-1:0]      wr_addr_q;
  reg                    wrapped_q;
  reg                    trig_pend_q;
  reg [31:0]             depth_q;
  reg [31:0]             post_cnt_q;
  reg [`CCM_AW-1:0]      trig_addr_q;
  reg [`CCM_AW-1:0]      end_addr_q;
  reg [`CCM_AW-1:0]      start_addr_q;
  reg [31:0]             dsrc_q;
  reg [31:0]             ddst_q;
  reg [31:0]             dlen_q;
  reg                    dma_busy_q;
  reg [`CCM_AW-1:0]      rd_ptr_q;
  reg [31:0]             remain_q;
  reg [2:0]              istat_q;
  reg [2:0]              imask_q;
  reg                    aw_full_q;
  reg                    w_full_q;
  reg [`CCM_BUS_AW-1:0]  aw_addr_q;
  reg [31:0]             w_data_q;
  reg [3:0]              w_strb_q;
  reg [`CCM_SW-1:0]      d1_q;
  reg [`CCM_SW-1:0]      d2_q;
  reg [`CCM_SW-1:0]      d3_q;
  reg [`CCM_SW-1:0]      d4_q;

  wire samp_tick;
  wire trig_rise;

  // ----------------------------------------------------------------------
  // pin inputs
  // ----------------------------------------------------------------------
  ccm_sync u_sclk (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin     (samp_clk_pin),
    .level_q (),
    .rise_q  (samp_tick)
  );

  ccm_sync u_trig (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin     (trig_pin),
    .level_q (),
    .rise_q  (trig_rise)
  );

  // data delayed to line up with the sample edge pulse; the adc holds its
  // output long after its clock edge, so no per-bit agreement is needed
  always @(posedge aclk) begin
    d1_q <= samp_data_pin;
    d2_q <= d1_q;
    d3_q <= d2_q;
    d4_q <= d3_q;
  end

  // ----------------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------------
  wire wr_en   = aw_full_q & w_full_q & ~s_axi_bvalid;
  wire wr_mem  = in_mem(aw_addr_q);
  wire [31:0] wr_ctl = (wr_en && aw_addr_q == `CCM_OFF_CTRL) ? w_data_q : 32'h0000_0000;
  wire acq_go  = wr_ctl[`CCM_CTRL_ACQ] & w_strb_q[0] & ~busy;
  wire dma_go  = wr_ctl[`CCM_CTRL_DMA] & w_strb_q[0] & ~busy & ~dma_busy_q;
  wire ftrig   = wr_ctl[`CCM_CTRL_FTRIG] & w_strb_q[0];
  wire trig_now = trig_pend_q | trig_rise | ftrig;
  wire last_post = (post_cnt_q == 32'h0000_0001);
  wire finish  = samp_tick &&
                 ((state_q == ST_PRE && trig_now && depth_q == 32'h0000_0000) ||
                  (state_q == ST_POST && last_post));
  wire dma_fin = dma_valid & dma_ready & (remain_q == 32'h0000_0000);

  // ----------------------------------------------------------------------
  // axi write channels: address and data taken in either order
  // ----------------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q     <= 1'b0;
      w_full_q      <= 1'b0;
      aw_addr_q     <= {`CCM_BUS_AW{1'b0}};
      w_data_q      <= 32'h0000_0000;
      w_strb_q      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `CCM_RESP_OK;
    end else begin
      s_axi_awready <= ~aw_full_q & ~(s_axi_awvalid & s_axi_awready);
      s_axi_wready  <= ~w_full_q & ~(s_axi_wvalid & s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_en) begin
        aw_full_q    <= 1'b0;
        w_full_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // memory window is read-only; unmapped words decode-error
        if (wr_mem)
          s_axi_bresp <= `CCM_RESP_ERR;
        else if (aw_addr_q > `CCM_OFF_IMASK || aw_addr_q[1:0] != 2'h0)
          s_axi_bresp <= `CCM_RESP_DEC;
        else
          s_axi_bresp <= `CCM_RESP_OK;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      depth_q <= 32'h0000_0000;
      dsrc_q  <= 32'h0000_0000;
      ddst_q  <= 32'h0000_0000;
      dlen_q  <= 32'h0000_0000;
      imask_q <= 3'h0;
      istat_q <= 3'h0;
      irq     <= 1'b0;
    end else begin
      if (wr_en && !wr_mem) begin
        case (aw_addr_q)
          `CCM_OFF_DEPTH: depth_q <= merge(depth_q, w_data_q, w_strb_q);
          `CCM_OFF_DSRC:  dsrc_q  <= merge(dsrc_q, w_data_q, w_strb_q);
          `CCM_OFF_DDST:  ddst_q  <= merge(ddst_q, w_data_q, w_strb_q);
          `CCM_OFF_DLEN:  dlen_q  <= merge(dlen_q, w_data_q, w_strb_q);
          `CCM_OFF_IMASK: imask_q <= w_strb_q[0] ? w_data_q[2:0] : imask_q;
          default: ;
        endcase
      end
      // write-one-to-clear; a new event in the same cycle wins
      istat_q <= (istat_q & ~((wr_en && aw_addr_q == `CCM_OFF_ISTAT && w_strb_q[0]) ?
                              w_data_q[2:0] : 3'h0))
                 | {samp_tick & trig_now & (state_q == ST_PRE), dma_fin, finish};
      irq     <= |(istat_q & imask_q);
    end
  end

  // ----------------------------------------------------------------------
  // acquisition sequencer
  // ----------------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_q      <= ST_IDLE;
      busy         <= 1'b0;
      wr_addr_q    <= {`CCM_AW{1'b0}};
      wrapped_q    <= 1'b0;
      trig_pend_q  <= 1'b0;
      post_cnt_q   <= 32'h0000_0000;
      trig_addr_q  <= {`CCM_AW{1'b0}};
      end_addr_q   <= {`CCM_AW{1'b0}};
      start_addr_q <= {`CCM_AW{1'b0}};
    end else if (acq_go) begin
      state_q     <= ST_PRE;
      busy        <= 1'b1;
      wr_addr_q   <= {`CCM_AW{1'b0}};
      wrapped_q   <= 1'b0;
      trig_pend_q <= 1'b0;
    end else begin
      case (state_q)
        ST_PRE: begin
          // a trigger between sample edges waits for the next sample
          if (!samp_tick)
            trig_pend_q <= trig_pend_q | trig_rise | ftrig;
          else if (trig_now) begin
            trig_pend_q <= 1'b0;
            trig_addr_q <= wr_addr_q;
            post_cnt_q  <= depth_q;
            if (depth_q != 32'h0000_0000)
              state_q <= ST_POST;
          end
        end
        ST_POST: begin
          if (samp_tick)
            post_cnt_q <= post_cnt_q - 32'h0000_0001;
        end
        default: state_q <= ST_IDLE;
      endcase
      if (finish) begin
        state_q      <= ST_IDLE;
        busy         <= 1'b0;
        end_addr_q   <= wr_addr_q;
        start_addr_q <= wrapped_q ? wr_addr_q + 1'b1 : {`CCM_AW{1'b0}};
      end else if (samp_tick && state_q != ST_IDLE) begin
        wr_addr_q <= wr_addr_q + 1'b1;
        if (wr_addr_q == LAST_ADDR) begin
          wr_addr_q <= {`CCM_AW{1'b0}};
          wrapped_q <= 1'b1;
        end
      end
    end
  end

  // one word stored per sample clock rising edge
  always @(posedge aclk) begin
    if (samp_tick && state_q != ST_IDLE && !acq_go)
      mem[wr_addr_q] <= d4_q;
  end

  // ----------------------------------------------------------------------
  // bus-master transfer engine
  // ----------------------------------------------------------------------
  // one sample per host word, low bits, addresses step by four bytes
  always @(posedge aclk) begin
    if (!aresetn) begin
      dma_busy_q <= 1'b0;
      dma_valid  <= 1'b0;
      dma_addr   <= 32'h0000_0000;
      dma_data   <= 32'h0000_0000;
      rd_ptr_q   <= {`CCM_AW{1'b0}};
      remain_q   <= 32'h0000_0000;
    end else if (dma_go) begin
      dma_busy_q <= (dlen_q != 32'h0000_0000);
      rd_ptr_q   <= dsrc_q[`CCM_AW-1:0];
      remain_q   <= dlen_q;
      dma_addr   <= ddst_q - 32'h0000_0004;
    end else if (dma_busy_q) begin
      if (dma_valid && dma_ready) begin
        dma_valid <= 1'b0;
        if (remain_q == 32'h0000_0000)
          dma_busy_q <= 1'b0;
      end else if (!dma_valid) begin
        dma_valid <= 1'b1;
        dma_data  <= {{(32-`CCM_SW){1'b0}}, mem[rd_ptr_q]};
        dma_addr  <= dma_addr + 32'h0000_0004;
        rd_ptr_q  <= rd_ptr_q + 1'b1;
        remain_q  <= remain_q - 32'h0000_0001;
      end
    end
  end

  // ----------------------------------------------------------------------
  // axi read channel
  // ----------------------------------------------------------------------
  wire [`CCM_AW-1:0] rd_idx = s_axi_araddr[`CCM_AW+1:2];

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `CCM_RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= `CCM_RESP_OK;
      s_axi_rdata   <= 32'h0000_0000;
      if (in_mem(s_axi_araddr)) begin
        if (busy)
          s_axi_rresp <= `CCM_RESP_ERR;
        else
          s_axi_rdata <= {{(32-`CCM_SW){1'b0}}, mem[rd_idx]};
      end else begin
        case (s_axi_araddr)
          `CCM_OFF_CTRL:  s_axi_rdata <= 32'h0000_0000;
          `CCM_OFF_STAT:  s_axi_rdata <= {28'h0000000, trig_pend_q, dma_busy_q,
                                          wrapped_q, busy};
          `CCM_OFF_DEPTH: s_axi_rdata <= depth_q;
          `CCM_OFF_TRIG:  s_axi_rdata <= {{(32-`CCM_AW){1'b0}}, trig_addr_q};
          `CCM_OFF_END:   s_axi_rdata <= {{(32-`CCM_AW){1'b0}}, end_addr_q};
          `CCM_OFF_START: s_axi_rdata <= {{(32-`CCM_AW){1'b0}}, start_addr_q};
          `CCM_OFF_DSRC:  s_axi_rdata <= dsrc_q;
          `CCM_OFF_DDST:  s_axi_rdata <= ddst_q;
          `CCM_OFF_DLEN:  s_axi_rdata <= dlen_q;
          `CCM_OFF_ISTAT: s_axi_rdata <= {29'h00000000, istat_q};
          `CCM_OFF_IMASK: s_axi_rdata <= {29'h00000000, imask_q};
          default:        s_axi_rresp <= `CCM_RESP_DEC;
        endcase
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end else begin
      s_axi_arready <= ~s_axi_rvalid;
    end
  end
endmodule
`default_nettype wire

// File: ccm_defs.vh
// ----------------------------------------------------------------------
// circular capture memory: constants
// ----------------------------------------------------------------------
// Overview of operation
// - acquisition memory is readable as a window in the host bus space.
// - software loads source start, host destination and sample count first.
// - on request the block moves those samples to host memory by itself.
// - commanding acquisition start raises the busy indication.
// - host access to acquisition memory is refused while busy.
// - acquisition start clears the write counter; each sample increments it.
// - samples keep being stored as pre-trigger data until a trigger.
// - after a trigger exactly the programmed post-trigger depth is stored.
// - when post-trigger count completes, stop, drop busy, reopen memory.
// - write address wraps from the last word to zero, overwriting.
// - the write address at trigger detection is kept as trigger address.
// - last stored address is the end; the next one is the start.
// - without a wrap, the reported start address is zero.
// - one sample is taken on each rising sample clock edge.
`ifndef CCM_DEFS_VH
`define CCM_DEFS_VH

// ----------------------------------------------------------------------
// sizes
// ----------------------------------------------------------------------
`define CCM_AW        10
`define CCM_DEPTH     1024
`define CCM_SW        16
`define CCM_BUS_AW    13

// ----------------------------------------------------------------------
// register byte offsets and memory window bit
// ----------------------------------------------------------------------
`define CCM_OFF_CTRL   13'h0000
`define CCM_OFF_STAT   13'h0004
`define CCM_OFF_DEPTH  13'h0008
`define CCM_OFF_TRIG   13'h000C
`define CCM_OFF_END    13'h0010
`define CCM_OFF_START  13'h0014
`define CCM_OFF_DSRC   13'h0018
`define CCM_OFF_DDST   13'h001C
`define CCM_OFF_DLEN   13'h0020
`define CCM_OFF_ISTAT  13'h0024
`define CCM_OFF_IMASK  13'h0028
`define CCM_MEM_BIT    12

// ----------------------------------------------------------------------
// field positions and codes
// ----------------------------------------------------------------------
`define CCM_CTRL_ACQ   0
`define CCM_CTRL_DMA   1
`define CCM_CTRL_FTRIG 2
`define CCM_EV_ACQ     0
`define CCM_EV_DMA     1
`define CCM_EV_TRIG    2
`define CCM_RESP_OK    2'h0
`define CCM_RESP_ERR   2'h2
`define CCM_RESP_DEC   2'h3

`endif

// File: ccm_sync.v
`default_nettype none
// ----------------------------------------------------------------------
// three-stage pin synchroniser with rising-edge pulse
// ----------------------------------------------------------------------
module ccm_sync (
  input  wire aclk,
  input  wire aresetn,
  input  wire pin,
  output reg  level_q,
  output reg  rise_q
);
  reg s1_q;
  reg s2_q;
  reg s3_q;

  // level only moves once stages two and three agree
  always @(posedge aclk) begin
    if (!aresetn) begin
      s1_q    <= 1'b0;
      s2_q    <= 1'b0;
      s3_q    <= 1'b0;
      level_q <= 1'b0;
      rise_q  <= 1'b0;
    end else begin
      s1_q    <= pin;
      s2_q    <= s1_q;
      s3_q    <= s2_q;
      rise_q  <= 1'b0;
      if (s2_q == s3_q) begin
        level_q <= s3_q;
        rise_q  <= s3_q & ~level_q;
      end
    end
  end
endmodule
`default_nettype wire

// File: ccm_props.sv
`include "ccm_defs.vh"
`default_nettype none
module ccm_props (
  input wire logic                   aclk,
  input wire logic                   aresetn,
  input wire logic                   s_axi_awready,
  input wire logic                   s_axi_wready,
  input wire logic                   s_axi_bvalid,
  input wire logic                   s_axi_arvalid,
  input wire logic                   s_axi_arready,
  input wire logic [`CCM_BUS_AW-1:0] s_axi_araddr,
  input wire logic                   s_axi_rvalid,
  input wire logic [31:0]            s_axi_rdata,
  input wire logic [1:0]             s_axi_rresp,
  input wire logic                   dma_valid,
  input wire logic                   dma_ready,
  input wire logic [31:0]            dma_addr,
  input wire logic [31:0]            dma_data,
  input wire logic                   busy,
  input wire logic                   irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // --------------------------------------------------------------------
  // register bus
  // --------------------------------------------------------------------
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered one cycle after address");
  rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while data pending");
  wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  dec_err_a: assert property (
    s_axi_arvalid && s_axi_arready && !s_axi_araddr[12] && s_axi_araddr[11:0] > 12'h028
    |=> s_axi_rresp == `CCM_RESP_DEC)
    else $error("unmapped read not decode error");

  // --------------------------------------------------------------------
  // memory window and acquisition
  // --------------------------------------------------------------------
  mem_refuse_a: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr[12] && busy
    |=> s_axi_rresp == `CCM_RESP_ERR && s_axi_rdata == 32'h0)
    else $error("memory read while busy not refused");
  mem_open_a: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr[12] && !busy
    |=> s_axi_rresp == `CCM_RESP_OK && s_axi_rdata[31:16] == 16'h0)
    else $error("memory read while idle refused");
  rst_quiet_a: assert property ($rose(aresetn) |-> !busy && !irq && !dma_valid)
    else $error("outputs active after reset");

  // --------------------------------------------------------------------
  // dma stream
  // --------------------------------------------------------------------
  dma_hold_a: assert property (
    dma_valid && !dma_ready |=> dma_valid && $stable(dma_addr) && $stable(dma_data))
    else $error("dma word changed before acceptance");
  dma_step_a: assert property (
    dma_valid && dma_ready ##1 !dma_valid ##1 dma_valid
    |-> dma_addr == $past(dma_addr, 2) + 32'h4)
    else $error("dma destination not ascending by one word");
endmodule
bind ccm_top ccm_props props_u (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .dma_valid(dma_valid),
  .dma_ready(dma_ready), .dma_addr(dma_addr), .dma_data(dma_data), .busy(busy), .irq(irq)
);
`default_nettype wire

// File: ccm_host_mdl.sv
`default_nettype none
module ccm_host_mdl (
  input  wire logic        aclk,
  input  wire logic        slow,
  input  wire logic        dma_valid,
  input  wire logic [31:0] dma_addr,
  input  wire logic [31:0] dma_data,
  output var  logic        dma_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] got_addr[$];
  logic [31:0] got_data[$];
  logic [1:0]  ph_q = 2'h0;
  initial dma_ready = 1'b0;
  // host memory controller: when slow, accept one cycle in three so the engine stalls
  always @(posedge aclk) begin
    if (dma_valid && dma_ready) begin
      got_addr.push_back(dma_addr);
      got_data.push_back(dma_data);
    end
    ph_q      <= (ph_q == 2'h2) ? 2'h0 : ph_q + 2'h1;
    dma_ready <= slow ? (ph_q == 2'h0) : 1'b1;
  end
endmodule
`default_nettype wire

// File: test_circular_capture_memory.sv
`include "ccm_defs.vh"
`default_nettype none
module test_circular_capture_memory;
  timeunit 1ns;
  timeprecision 1ps;
  // --------------------------------------------------------------------
  // signals
  // --------------------------------------------------------------------
  logic        aclk, aresetn, samp_clk_pin, trig_pin, slow, dma_valid, dma_ready, busy, irq;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [3:0]  s_axi_wstrb;
  logic [12:0] s_axi_awaddr, s_axi_araddr;
  logic [15:0] samp_data_pin;
  logic [31:0] s_axi_wdata, s_axi_rdata, dma_addr, dma_data, rd;
  int          error_cnt, compares;

  initial aclk = 1'b0;
  always #4 aclk = ~aclk;

  ccm_top dut_u (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .samp_clk_pin(samp_clk_pin), .trig_pin(trig_pin), .samp_data_pin(samp_data_pin),
    .dma_valid(dma_valid), .dma_addr(dma_addr), .dma_data(dma_data), .dma_ready(dma_ready),
    .busy(busy), .irq(irq));
  ccm_host_mdl mdl_u (
    .aclk(aclk), .slow(slow), .dma_valid(dma_valid), .dma_addr(dma_addr),
    .dma_data(dma_data), .dma_ready(dma_ready));

  // --------------------------------------------------------------------
  // reporting
  // --------------------------------------------------------------------
  task automatic finish_test();
    $display("mismatches %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // a wait that ran out of cycles ends the run
  task automatic hang(input int n);
    if (n >= 200) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h (wait limit)", $time, n, 200);
      finish_test();
    end
  endtask

  // --------------------------------------------------------------------
  // bus and pin drivers
  // --------------------------------------------------------------------
  // leading edge keeps the ready release of the last transfer apart from this one
  task automatic axi_wr(input logic [12:0] a, input logic [31:0] d, input logic [3:0] s,
                        output logic [1:0] r);
    int n;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 200);
    hang(n);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [12:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 200);
    hang(n);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic wr(input logic [12:0] a, input logic [31:0] d);
    axi_wr(a, d, 4'hF, rsp);
    chk({30'h0, rsp}, {30'h0, `CCM_RESP_OK});
  endtask

  task automatic rd_chk(input logic [12:0] a, input logic [31:0] e, input logic [1:0] re);
    axi_rd(a, rd, rsp);
    chk(rd, e);
    chk({30'h0, rsp}, {30'h0, re});
  endtask

  // data held well past the sampling delay of the pin synchroniser
  task automatic samp(input logic [15:0] d);
    samp_data_pin <= d;
    samp_clk_pin  <= 1'b1;
    repeat (4) @(posedge aclk);
    samp_clk_pin  <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask

  // --------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------
  task automatic t_regs();
    rd_chk(`CCM_OFF_STAT, 32'h0, `CCM_RESP_OK);
    wr(`CCM_OFF_DEPTH, 32'h0000_0123);
    axi_wr(`CCM_OFF_DEPTH, 32'hFFFF_FF45, 4'h1, rsp);
    rd_chk(`CCM_OFF_DEPTH, 32'h0000_0145, `CCM_RESP_OK);
    wr(`CCM_OFF_DLEN, 32'h0000_0007);
    rd_chk(`CCM_OFF_DLEN, 32'h0000_0007, `CCM_RESP_OK);
    rd_chk(13'h002C, 32'h0, `CCM_RESP_DEC);
    axi_wr(13'h002C, 32'h0, 4'hF, rsp);
    chk({30'h0, rsp}, {30'h0, `CCM_RESP_DEC});
    axi_wr(13'h1000, 32'h0000_1234, 4'hF, rsp);
    chk({30'h0, rsp}, {30'h0, `CCM_RESP_ERR});
  endtask

  task automatic t_short();
    int k;
    wr(`CCM_OFF_IMASK, 32'h1);
    wr(`CCM_OFF_DEPTH, 32'h3);
    wr(`CCM_OFF_CTRL, 32'h1);
    chk({31'h0, busy}, 32'h1);
    rd_chk(13'h1000, 32'h0, `CCM_RESP_ERR);
    for (k = 0; k < 5; k++) samp(16'hA000 + k[15:0]);
    wr(`CCM_OFF_CTRL, 32'h4);
    for (k = 5; k < 9; k++) samp(16'hA000 + k[15:0]);
    repeat (4) @(posedge aclk);
    chk({31'h0, busy}, 32'h0);
    chk({31'h0, irq}, 32'h1);
    rd_chk(`CCM_OFF_TRIG, 32'h5, `CCM_RESP_OK);
    rd_chk(`CCM_OFF_END, 32'h8, `CCM_RESP_OK);
    rd_chk(`CCM_OFF_START, 32'h0, `CCM_RESP_OK);
    rd_chk(`CCM_OFF_STAT, 32'h0, `CCM_RESP_OK);
    for (k = 0; k < 9; k++) rd_chk(13'h1000 + 13'(4 * k), 32'h0000_A000 + k, 2'h0);
    rd_chk(`CCM_OFF_ISTAT, 32'h5, `CCM_RESP_OK);
    wr(`CCM_OFF_ISTAT, 32'h7);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
  endtask

  task automatic t_wrap();
    int k;
    wr(`CCM_OFF_DEPTH, 32'h2);
    wr(`CCM_OFF_CTRL, 32'h1);
    for (k = 0; k < 1030; k++) samp(16'hA000 + k[15:0]);
    trig_pin <= 1'b1;
    repeat (4) @(posedge aclk);
    trig_pin <= 1'b0;
    repeat (8) @(posedge aclk);
    for (k = 1030; k < 1033; k++) samp(16'hA000 + k[15:0]);
    repeat (4) @(posedge aclk);
    chk({31'h0, busy}, 32'h0);
    rd_chk(`CCM_OFF_TRIG, 32'h6, `CCM_RESP_OK);
    rd_chk(`CCM_OFF_END, 32'h8, `CCM_RESP_OK);
    rd_chk(`CCM_OFF_START, 32'h9, `CCM_RESP_OK);
    rd_chk(`CCM_OFF_STAT, 32'h2, `CCM_RESP_OK);
    rd_chk(13'h1020, 32'h0000_A408, `CCM_RESP_OK);
    rd_chk(13'h1024, 32'h0000_A009, `CCM_RESP_OK);
    wr(`CCM_OFF_ISTAT, 32'h7);
  endtask

  // source straddles the top of memory, host stalls the stream
  task automatic t_dma();
    int n;
    int k;
    slow <= 1'b1;
    wr(`CCM_OFF_DSRC, 32'h0000_03FE);
    wr(`CCM_OFF_DDST, 32'h0000_4000);
    wr(`CCM_OFF_DLEN, 32'h3);
    wr(`CCM_OFF_CTRL, 32'h2);
    n = 0;
    while (mdl_u.got_data.size() < 3 && n < 200) begin
      @(posedge aclk);
      n++;
    end
    hang(n);
    for (k = 0; k < 3; k++) begin
      chk(mdl_u.got_addr[k], 32'h0000_4000 + 4 * k);
      chk(mdl_u.got_data[k], 32'h0000_A3FE + k);
    end
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
    rd_chk(`CCM_OFF_ISTAT, 32'h2, `CCM_RESP_OK);
    wr(`CCM_OFF_IMASK, 32'h2);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h1);
    wr(`CCM_OFF_ISTAT, 32'h2);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
  endtask

  // zero post-trigger depth: the trigger sample itself ends the record
  task automatic t_zero();
    wr(`CCM_OFF_DEPTH, 32'h0);
    wr(`CCM_OFF_CTRL, 32'h1);
    repeat (2) samp(16'hB000);
    wr(`CCM_OFF_CTRL, 32'h4);
    samp(16'hB002);
    rd_chk(`CCM_OFF_END, 32'h2, `CCM_RESP_OK);
  endtask

  // --------------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------------
  initial begin
    error_cnt = 0;
    compares = 0;
    aresetn = 1'b0;
    {samp_clk_pin, trig_pin, slow, s_axi_awvalid, s_axi_wvalid} = 5'h0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready} = 3'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, samp_data_pin} = 46'h0;
    s_axi_wdata = 32'h0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_short();
    t_wrap();
    t_dma();
    t_zero();
    finish_test();
  end
endmodule
`default_nettype wire
